//--- sim/periodic_tick_timer_test.sv
`timescale 1ns/1ns
module periodic_tick_timer_test;

	logic clk;
	logic rst_n;
	logic time_base;
	tick_timer_pkg::bus_req_t bus_req;
	logic [tick_timer_pkg::DATA_W-1:0] bus_rdata;
	logic irq;
	logic [7:0] v;
	int fails;
	int n_tests;
	int k;

	periodic_tick_timer #(.PRESCALE(2)) u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.time_base(time_base),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.irq(irq)
	);

	// ----------------------------------------------------------------
	// Clock, slow time base, reset
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		time_base = 1'b0;
		rst_n = 1'b0;
		bus_req = '0;
		fails = 0;
		n_tests = 0;
	end

	always #4 clk = ~clk;

	// Time base rising edge every 8 clocks; a count step every 16 clocks
	always begin
		repeat (4) @(posedge clk);
		time_base <= ~time_base;
	end

	// ----------------------------------------------------------------
	// Bus tasks and compares
	// ----------------------------------------------------------------
	task automatic bus_write(input logic [15:0] addr, input logic [7:0] d);
		@(posedge clk);
		bus_req.addr <= addr;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [15:0] addr, output logic [7:0] d);
		@(posedge clk);
		bus_req.addr <= addr;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask : bus_read

	task automatic check_reg(input logic [15:0] addr, input logic [7:0] exp);
		logic [7:0] got;
		bus_read(addr, got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t reg %h got %h exp %h", $time, addr, got, exp);
		end
	endtask : check_reg

	task automatic check_irq(input logic exp);
		@(posedge clk);
		#1;
		n_tests++;
		if (irq !== exp) begin
			fails++;
			$display("ERROR t=%0t irq got %h exp %h", $time, irq, exp);
		end
	endtask : check_irq

	task automatic finish_test;
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		check_reg(tick_timer_pkg::CTRL_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::ENABLES_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h00);
		check_irq(1'b0);
		// Stopped timer ignores time base edges
		repeat (100) @(posedge clk);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h00);
		// Count is read-only, unmapped place reads zero
		bus_write(tick_timer_pkg::COUNT_OFFSET, 8'hAA);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h00);
		bus_write(16'h5004, 8'hFF);
		check_reg(16'h5004, 8'h00);
		bus_write(tick_timer_pkg::ENABLES_OFFSET, 8'hFF);
		check_reg(tick_timer_pkg::ENABLES_OFFSET, 8'h0F);
		bus_write(tick_timer_pkg::ENABLES_OFFSET, 8'h00);
		// Run until the first 32 Hz period ends at count 8
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h11);
		check_reg(tick_timer_pkg::CTRL_OFFSET, 8'h01);
		v = 8'h00;
		for (k = 0; k < 200 && v !== 8'h08; k++)
			bus_read(tick_timer_pkg::COUNT_OFFSET, v);
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h08);
		check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h08);
		repeat (100) @(posedge clk);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h08);
		// Clear bit written as one returns count to zero
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h10);
		check_reg(tick_timer_pkg::COUNT_OFFSET, 8'h00);
		bus_write(tick_timer_pkg::FLAGS_OFFSET, 8'h0F);
		check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h00);
		// A full wrap of the count raises every period flag
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h01);
		repeat (4300) @(posedge clk);
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h0F);
		check_irq(1'b0);
		bus_read(tick_timer_pkg::COUNT_OFFSET, v);
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::COUNT_OFFSET, v);
		bus_write(tick_timer_pkg::FLAGS_OFFSET, 8'h00);
		check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h0F);
		// Each enable gates only its own flag onto the interrupt
		for (k = 3; k >= 0; k--) begin
			bus_write(tick_timer_pkg::ENABLES_OFFSET, 8'h01 << k);
			check_irq(1'b1);
			bus_write(tick_timer_pkg::FLAGS_OFFSET, 8'h01 << k);
			check_irq(1'b0);
			check_reg(tick_timer_pkg::FLAGS_OFFSET, 8'h0F >> (4 - k));
		end
		// An enabled 32 Hz period raises the interrupt while running
		bus_write(tick_timer_pkg::ENABLES_OFFSET, 8'h08);
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h01);
		repeat (160) @(posedge clk);
		check_irq(1'b1);
		bus_write(tick_timer_pkg::CTRL_OFFSET, 8'h10);
		bus_write(tick_timer_pkg::FLAGS_OFFSET, 8'h0F);
		check_irq(1'b0);
		finish_test;
	end

endmodule : periodic_tick_timer_test

//--- verilog/periodic_tick_timer.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module periodic_tick_timer #(
	parameter int unsigned PRESCALE = tick_timer_pkg::PRESCALE_DIV
) (
	input wire logic clk, // System clock, 125 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic time_base, // Slow time base pin
	input wire tick_timer_pkg::bus_req_t bus_req, // Register request
	output logic [tick_timer_pkg::DATA_W-1:0] bus_rdata, // Read data
	output logic irq // Level interrupt request
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic run;
	logic [tick_timer_pkg::DATA_W-1:0] count;
	tick_timer_pkg::event_vec_t enables;
	tick_timer_pkg::event_vec_t flags;
	logic tick;

	function automatic logic wrapped(
		input logic [tick_timer_pkg::DATA_W-1:0] value,
		input logic [tick_timer_pkg::DATA_W-1:0] mask
	);
		return (value & mask) == mask;
	endfunction : wrapped

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire ctrl_sel = bus_req.addr == tick_timer_pkg::CTRL_OFFSET;
	wire count_sel = bus_req.addr == tick_timer_pkg::COUNT_OFFSET;
	wire enables_sel = bus_req.addr == tick_timer_pkg::ENABLES_OFFSET;
	wire flags_sel = bus_req.addr == tick_timer_pkg::FLAGS_OFFSET;

	wire ctrl_wr = bus_req.wr & ctrl_sel;
	wire enables_wr = bus_req.wr & enables_sel;
	wire flags_wr = bus_req.wr & flags_sel;
	wire clear_hit = ctrl_wr & bus_req.wdata[tick_timer_pkg::CLEAR_BIT];

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	tick_source #(
		.DIV(PRESCALE)
	) u_tick_source (
		.clk(clk),
		.rst_n(rst_n),
		.time_base(time_base),
		.run(run),
		.clear(clear_hit),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// Counter and period events
	// ------------------------------------------------------------
	wire step = tick & run & ~clear_hit;
	wire [tick_timer_pkg::DATA_W-1:0] count_inc =
		tick_timer_pkg::DATA_W'(count + 1'b1);
	wire [tick_timer_pkg::DATA_W-1:0] next_count =
		clear_hit ? tick_timer_pkg::COUNT_RESET :
		step ? count_inc : count;
	wire next_run = ctrl_wr ? bus_req.wdata[tick_timer_pkg::RUN_BIT] : run;

	tick_timer_pkg::event_vec_t events;
	assign events[tick_timer_pkg::BIT_32HZ] =
		step & wrapped(count, tick_timer_pkg::WRAP_32HZ);
	assign events[tick_timer_pkg::BIT_8HZ] =
		step & wrapped(count, tick_timer_pkg::WRAP_8HZ);
	assign events[tick_timer_pkg::BIT_2HZ] =
		step & wrapped(count, tick_timer_pkg::WRAP_2HZ);
	assign events[tick_timer_pkg::BIT_1HZ] =
		step & wrapped(count, tick_timer_pkg::WRAP_1HZ);

	// ------------------------------------------------------------
	// Enables, flags and interrupt
	// ------------------------------------------------------------
	wire tick_timer_pkg::event_vec_t flag_clr = flags_wr ?
		bus_req.wdata[tick_timer_pkg::EVENT_W-1:0] : '0;
	wire tick_timer_pkg::event_vec_t next_flags =
		(flags & ~flag_clr) | events;
	wire tick_timer_pkg::event_vec_t next_enables = enables_wr ?
		bus_req.wdata[tick_timer_pkg::EVENT_W-1:0] : enables;
	wire next_irq = |(next_flags & next_enables);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [tick_timer_pkg::DATA_W-1:0] ctrl_view =
		tick_timer_pkg::DATA_W'(run);
	wire [tick_timer_pkg::DATA_W-1:0] enables_view =
		tick_timer_pkg::DATA_W'(enables);
	wire [tick_timer_pkg::DATA_W-1:0] flags_view =
		tick_timer_pkg::DATA_W'(flags);
	wire [tick_timer_pkg::DATA_W-1:0] next_rdata =
		!bus_req.rd ? tick_timer_pkg::RDATA_RESET :
		ctrl_sel ? ctrl_view :
		count_sel ? count :
		enables_sel ? enables_view :
		flags_sel ? flags_view :
		tick_timer_pkg::RDATA_RESET;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= tick_timer_pkg::RUN_RESET;
			count <= tick_timer_pkg::COUNT_RESET;
			enables <= tick_timer_pkg::ENABLES_RESET;
			flags <= tick_timer_pkg::FLAGS_RESET;
		end else begin
			run <= next_run;
			count <= next_count;
			enables <= next_enables;
			flags <= next_flags;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= tick_timer_pkg::RDATA_RESET;
			irq <= 1'b0;
		end else begin
			bus_rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Check helpers: time base edges counted since the last tick
	// ------------------------------------------------------------
	localparam int unsigned EW = $clog2(PRESCALE + 1);

	logic base_meta;
	logic base_sync;
	logic base_last;
	logic [EW-1:0] base_edges;

	wire base_rise = base_sync & ~base_last;
	wire base_counted = base_rise & run & ~clear_hit;
	wire [EW-1:0] base_from = (tick | clear_hit) ? '0 : base_edges;
	wire [EW-1:0] next_base_edges = base_counted ?
		EW'(base_from + 1'b1) : base_from;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base_meta <= 1'b0;
			base_sync <= 1'b0;
			base_last <= 1'b0;
			base_edges <= '0;
		end else begin
			base_meta <= time_base;
			base_sync <= base_meta;
			base_last <= base_sync;
			base_edges <= next_base_edges;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_STOP_HOLDS: assert property (
		!run && !clear_hit |=> $stable(count))
		else $error("count moved while stopped");

	AST_RUN_STEPS: assert property (
		tick && run && !clear_hit |=>
		count == tick_timer_pkg::DATA_W'($past(count) + 1'b1))
		else $error("count did not step on a tick while running");

	AST_RUN_READBACK: assert property (
		ctrl_wr ##1 !ctrl_wr ##1 (bus_req.rd && ctrl_sel) |=>
		bus_rdata[tick_timer_pkg::RUN_BIT] ==
		$past(bus_req.wdata[tick_timer_pkg::RUN_BIT], 3))
		else $error("run bit did not read back as written");

	AST_COUNT_READ: assert property (
		bus_req.rd && count_sel |=> bus_rdata == $past(count))
		else $error("count read returned a wrong value");

	AST_COUNT_READONLY: assert property (
		bus_req.wr && count_sel && !tick |=> $stable(count))
		else $error("a write changed the read-only count");

	AST_IRQ_32HZ: assert property (
		flags[tick_timer_pkg::BIT_32HZ] &&
		enables[tick_timer_pkg::BIT_32HZ] |-> irq)
		else $error("enabled 32 Hz flag without interrupt");

	AST_IRQ_8HZ: assert property (
		flags[tick_timer_pkg::BIT_8HZ] &&
		enables[tick_timer_pkg::BIT_8HZ] |-> irq)
		else $error("enabled 8 Hz flag without interrupt");

	AST_IRQ_MASKED: assert property (
		(flags & enables) == '0 |-> !irq)
		else $error("interrupt raised with no enabled flag");

	AST_IRQ_SLOW: assert property (
		(flags[tick_timer_pkg::BIT_2HZ] &&
		enables[tick_timer_pkg::BIT_2HZ]) ||
		(flags[tick_timer_pkg::BIT_1HZ] &&
		enables[tick_timer_pkg::BIT_1HZ]) |-> irq)
		else $error("enabled slow flag without interrupt");

	AST_FLAG_SETS: assert property (
		step && wrapped(count, tick_timer_pkg::WRAP_32HZ) |=>
		flags[tick_timer_pkg::BIT_32HZ])
		else $error("32 Hz flag not set at period end");

	AST_FLAG_1HZ_WRAP: assert property (
		step && count == tick_timer_pkg::WRAP_1HZ |=>
		flags == 4'hF && count == tick_timer_pkg::COUNT_RESET)
		else $error("count wrap did not raise every flag");

	AST_FLAG_CLEARS: assert property (
		flags_wr && bus_req.wdata[tick_timer_pkg::BIT_8HZ] &&
		!events[tick_timer_pkg::BIT_8HZ] |=>
		!flags[tick_timer_pkg::BIT_8HZ])
		else $error("8 Hz flag not cleared by a written one");

	AST_FLAG_ZERO_KEEPS: assert property (
		flags_wr && bus_req.wdata[tick_timer_pkg::EVENT_W-1:0] == '0 |=>
		flags == $past(flags | events))
		else $error("writing zeros changed the flags");

	AST_CLEAR_COUNT: assert property (
		clear_hit |=> count == tick_timer_pkg::COUNT_RESET ##1
		!tick)
		else $error("counter reset left count or prescaler running");

	AST_CLEAR_ZERO_IGNORED: assert property (
		ctrl_wr && !bus_req.wdata[tick_timer_pkg::CLEAR_BIT] &&
		!step |=> $stable(count))
		else $error("writing zero to the reset bit changed the count");

	AST_RUN_WRITE: assert property (
		ctrl_wr |=> run == $past(bus_req.wdata[tick_timer_pkg::RUN_BIT]))
		else $error("run bit did not take the written value");

	AST_RUN_HOLDS: assert property (
		!ctrl_wr |=> $stable(run))
		else $error("run bit changed without a control write");

	AST_CTRL_READ: assert property (
		bus_req.rd && ctrl_sel |=>
		bus_rdata == tick_timer_pkg::DATA_W'($past(run)))
		else $error("control read showed more than the run bit");

	AST_COUNT_ONLY_STEPS: assert property (
		!step && !clear_hit |=> $stable(count))
		else $error("count moved without a step or a clear");

	AST_STOP_NO_FLAG: assert property (
		!run && !flags_wr |=> flags == $past(flags))
		else $error("a flag rose while the timer was stopped");

	AST_TICK_PACE: assert property (
		tick |-> base_edges == EW'(PRESCALE))
		else $error("tick came after the wrong number of edges");

	AST_EDGES_BOUND: assert property (
		base_edges <= EW'(PRESCALE))
		else $error("time base edges passed without a tick");

	AST_RDATA_IDLE: assert property (
		!bus_req.rd |=> bus_rdata == tick_timer_pkg::RDATA_RESET)
		else $error("read data stood outside its cycle");

	AST_ENABLES_WRITE: assert property (
		enables_wr |=>
		enables == $past(bus_req.wdata[tick_timer_pkg::EVENT_W-1:0]))
		else $error("enables did not take the written value");

	AST_IRQ_CLEARED: assert property (
		flags_wr && bus_req.wdata[tick_timer_pkg::EVENT_W-1:0] == 4'hF &&
		events == '0 |=> !irq)
		else $error("interrupt stayed up after every flag was cleared");

	AST_ENABLES_HOLD: assert property (
		!enables_wr |=> $stable(enables))
		else $error("enables changed without a write");

	AST_ENABLES_READ: assert property (
		bus_req.rd && enables_sel |=>
		bus_rdata == tick_timer_pkg::DATA_W'($past(enables)))
		else $error("enables read returned a wrong value");

	AST_IRQ_1HZ: assert property (
		flags[tick_timer_pkg::BIT_1HZ] &&
		enables[tick_timer_pkg::BIT_1HZ] |-> irq)
		else $error("enabled 1 Hz flag without interrupt");

	AST_FLAGS_READ: assert property (
		bus_req.rd && flags_sel |=>
		bus_rdata == tick_timer_pkg::DATA_W'($past(flags)))
		else $error("flags read returned a wrong value");

	AST_FLAG_8HZ_SETS: assert property (
		step && wrapped(count, tick_timer_pkg::WRAP_8HZ) |=>
		flags[tick_timer_pkg::BIT_8HZ])
		else $error("8 Hz flag not set at period end");

	AST_FLAG_2HZ_SETS: assert property (
		step && wrapped(count, tick_timer_pkg::WRAP_2HZ) |=>
		flags[tick_timer_pkg::BIT_2HZ])
		else $error("2 Hz flag not set at period end");

	AST_FLAG_32HZ_PACE: assert property (
		!flags_wr && !(step && wrapped(count, tick_timer_pkg::WRAP_32HZ))
		|=> $stable(flags[tick_timer_pkg::BIT_32HZ]))
		else $error("32 Hz flag changed outside its period end");

	AST_FLAG_QUIET: assert property (
		!step && !flags_wr |=> $stable(flags))
		else $error("flags changed with no event and no write");

	AST_FLAG_SET_WINS: assert property (
		events != '0 |=> (flags & $past(events)) == $past(events))
		else $error("a period event was lost to a flag clear");

	AST_CLEAR_KEEPS_FLAGS: assert property (
		clear_hit |=> flags == $past(flags))
		else $error("counter reset raised or dropped a flag");

	COV_32HZ: cover property (
		events[tick_timer_pkg::BIT_32HZ] ##1 irq);
	COV_1HZ: cover property (events[tick_timer_pkg::BIT_1HZ]);
	COV_CLEAR_RUNNING: cover property (run && clear_hit);
	COV_SET_AND_CLEAR: cover property (
		flags_wr && (events & bus_req.wdata[3:0]) != '0);
	COV_COUNT_WRAP: cover property (step && count == tick_timer_pkg::WRAP_1HZ);

endmodule : periodic_tick_timer

//--- verilog/tick_source.sv
`timescale 1ns/1ns
module tick_source #(
	parameter int unsigned DIV = tick_timer_pkg::PRESCALE_DIV
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic time_base, // Slow time base pin
	input wire logic run, // Prescaler advances while high
	input wire logic clear, // Returns prescaler to zero
	output logic tick // One-cycle pulse per count step
);

	localparam int unsigned PW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [PW-1:0] LAST = PW'(DIV - 1);

	logic sync_meta;
	logic sync_stable;
	logic sync_prev;
	logic [PW-1:0] prescaler;

	wire base_edge = sync_stable & ~sync_prev;
	wire advance = run & base_edge & ~clear;
	wire at_last = (prescaler == LAST);

	// ------------------------------------------------------------
	// Two-stage synchroniser and rising edge detect
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta <= 1'b0;
			sync_stable <= 1'b0;
			sync_prev <= 1'b0;
		end else begin
			sync_meta <= time_base;
			sync_stable <= sync_meta;
			sync_prev <= sync_stable;
		end
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaler <= '0;
			tick <= 1'b0;
		end else begin
			if (clear) begin
				prescaler <= '0;
			end else if (advance) begin
				prescaler <= at_last ? '0 : PW'(prescaler + 1'b1);
			end
			tick <= advance & at_last;
		end
	end

endmodule : tick_source

//--- verilog/tick_timer_pkg.sv
package tick_timer_pkg;

	// ------------------------------------------------------------
	// Bus shape
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned EVENT_W = 4;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 16'h5000;
	localparam logic [ADDR_W-1:0] COUNT_OFFSET = 16'h5001;
	localparam logic [ADDR_W-1:0] ENABLES_OFFSET = 16'h5002;
	localparam logic [ADDR_W-1:0] FLAGS_OFFSET = 16'h5003;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned RUN_BIT = 0;
	localparam int unsigned CLEAR_BIT = 4;
	localparam int unsigned BIT_32HZ = 3;
	localparam int unsigned BIT_8HZ = 2;
	localparam int unsigned BIT_2HZ = 1;
	localparam int unsigned BIT_1HZ = 0;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic RUN_RESET = 1'b0;
	localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [EVENT_W-1:0] ENABLES_RESET = 4'h0;
	localparam logic [EVENT_W-1:0] FLAGS_RESET = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;

	// ------------------------------------------------------------
	// Count low bits that are all ones just before each period ends
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] WRAP_32HZ = 8'h07;
	localparam logic [DATA_W-1:0] WRAP_8HZ = 8'h1F;
	localparam logic [DATA_W-1:0] WRAP_2HZ = 8'h7F;
	localparam logic [DATA_W-1:0] WRAP_1HZ = 8'hFF;

	// ------------------------------------------------------------
	// Time base: edges of the slow input per count step
	// ------------------------------------------------------------
	localparam int unsigned TIME_BASE_HZ = 32768;
	localparam int unsigned TICK_HZ = 256;
	localparam int unsigned PRESCALE_DIV = TIME_BASE_HZ / TICK_HZ;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef logic [EVENT_W-1:0] event_vec_t;

endpackage : tick_timer_pkg
